/* File: rtl/quad_encoder_input.sv */
/*
 Dual quadrature encoder input with limit switch sensing, 32-bit position
 counters, speed sampling and a classic Wishbone register slave.
 Assumes comparator outputs arrive asynchronously on QUAD_LEVEL and
 SWITCH_LOW, and that THRESH_CODE drives the threshold DAC.
*/
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module quad_encoder_input #(
   parameter int unsigned INTERVAL_CYCLES = qenc_pkg::INTERVAL_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [5:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Comparators: bit 0/1 first encoder A/B, bit 2/3 second encoder A/B
   input wire logic [3:0] QUAD_LEVEL,
   input wire logic [3:0] SWITCH_LOW,
   // Threshold DAC and interrupt
   output logic [7:0] THRESH_CODE,
   output logic IRQ
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] s1_reg;
   logic [7:0] s2_reg;
   logic [7:0] s3_reg;
   logic [7:0] lvl_reg;
   logic [7:0] agree;
   logic [3:0] quad;
   logic [3:0] sw;
   logic [3:0] sw_prev_reg;
   logic [1:0] hold;
   wire [1:0] up_w;
   wire [1:0] down_w;
   wire [1:0] bad_w;
   logic [1:0] wrap;
   logic [1:0] cnt_wr;
   logic [31:0] count_reg [2];
   logic [31:0] last_reg [2];
   logic [31:0] delta [2];
   logic [7:0] speed_reg [2];
   logic [31:0] base_cnt_reg;
   logic [7:0] tb_cnt_reg;
   logic base_tick;
   logic sample_tick;
   logic [7:0] thresh_reg;
   logic [7:0] tbase_reg;
   logic [7:0] ist_reg;
   logic [7:0] ien_reg;
   logic [7:0] events;
   logic [7:0] clr;
   logic irq_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic acc;
   logic wr;
   logic [31:0] rdata;

   // Byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            m[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // Clamp a counter change to the speed range -127..127 (SPD_MIN..SPD_MAX)
   function automatic logic [7:0] speed_sat(input logic [31:0] d);
      if ($signed(d) > $signed(32'h0000007F))
      begin
         return qenc_pkg::SPD_MAX;
      end
      else if ($signed(d) < $signed(32'hFFFFFF81))
      begin
         return qenc_pkg::SPD_MIN;
      end
      return d[7:0];
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // A change is taken only once stages two and three agree
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
         s3_reg <= 8'h00;
         lvl_reg <= 8'h00;
      end
      else
      begin
         s1_reg <= {SWITCH_LOW, QUAD_LEVEL};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= (lvl_reg & ~agree) | (s3_reg & agree);
      end
   end

   assign agree = s2_reg ~^ s3_reg;
   // Only the threshold comparator feeds the decoder; index or differential lines do not exist
   assign quad = lvl_reg[3:0];
   // The fixed low detector alone drives switch status, so encoder lows that reach it read as closed switches
   assign sw = lvl_reg[7:4];
   // Switches 1,2 share the first encoder's inputs, 3,4 the second's
   assign hold = {sw[3] | sw[2], sw[1] | sw[0]};

   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   for (genvar e = 0; e < 2; e++)
   begin : g_enc
      quad_if qi ();
      assign qi.quad_phase_first = quad[2*e];
      assign qi.quad_phase_second = quad[2*e+1];
      assign qi.hold = hold[e];
      assign up_w[e] = qi.up;
      assign down_w[e] = qi.down;
      assign bad_w[e] = qi.bad;
      quad_decoder u_dec (
         .clk (REF_CLK),
         .rst (RST),
         .q (qi.dec)
      );
      assign wrap[e] = (up_w[e] & (count_reg[e] == qenc_pkg::CNT_MAX))
                     | (down_w[e] & (count_reg[e] == qenc_pkg::CNT_MIN));
      assign delta[e] = count_reg[e] - last_reg[e];
   end

   // ----------------------------------------
   // Position counters
   // ----------------------------------------
   // A bus write to a counter wins over a count in the same cycle
   always_ff @(posedge REF_CLK)
   begin
      for (int e = 0; e < 2; e++)
      begin
         if (RST)
         begin
            count_reg[e] <= 32'h00000000;
         end
         else if (cnt_wr[e])
         begin
            count_reg[e] <= merge(count_reg[e], WB_DAT_I, WB_SEL_I);
         end
         else if (wrap[e])
         begin
            count_reg[e] <= 32'h00000000;
         end
         else if (up_w[e])
         begin
            count_reg[e] <= count_reg[e] + 32'h00000001;
         end
         else if (down_w[e])
         begin
            count_reg[e] <= count_reg[e] - 32'h00000001;
         end
      end
   end

   // ----------------------------------------
   // Speed time base
   // ----------------------------------------
   assign base_tick = (base_cnt_reg == INTERVAL_CYCLES - 1);
   // A time base lowered mid-window ends that window at the next tick instead of waiting for a wrap
   assign sample_tick = base_tick & (tb_cnt_reg >= tbase_reg);

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         base_cnt_reg <= 32'h00000000;
         tb_cnt_reg <= 8'h00;
      end
      else
      begin
         base_cnt_reg <= base_tick ? 32'h00000000 : base_cnt_reg + 32'h00000001;
         if (sample_tick)
         begin
            tb_cnt_reg <= 8'h00;
         end
         else if (base_tick)
         begin
            tb_cnt_reg <= tb_cnt_reg + 8'h01;
         end
      end
   end

   // Speed freezes while a switch hides that encoder's signal
   always_ff @(posedge REF_CLK)
   begin
      for (int e = 0; e < 2; e++)
      begin
         if (RST)
         begin
            last_reg[e] <= 32'h00000000;
            speed_reg[e] <= 8'h00;
         end
         else if (sample_tick)
         begin
            last_reg[e] <= count_reg[e];
            if (!hold[e])
            begin
               speed_reg[e] <= speed_sat(delta[e]);
            end
         end
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   assign acc = WB_CYC_I & WB_STB_I & ~ack_reg;
   assign wr = acc & WB_WE_I;
   assign cnt_wr[0] = wr & (WB_ADR_I == qenc_pkg::OFS_COUNT0);
   assign cnt_wr[1] = wr & (WB_ADR_I == qenc_pkg::OFS_COUNT1);

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         thresh_reg <= qenc_pkg::THRESH_RST;
         tbase_reg <= qenc_pkg::TBASE_RST;
         ien_reg <= 8'h00;
      end
      else if (wr)
      begin
         unique case (WB_ADR_I)
            qenc_pkg::OFS_THRESH: thresh_reg <= WB_SEL_I[0] ? WB_DAT_I[7:0] : thresh_reg;
            qenc_pkg::OFS_TBASE: tbase_reg <= WB_SEL_I[0] ? WB_DAT_I[7:0] : tbase_reg;
            qenc_pkg::OFS_IEN: ien_reg <= WB_SEL_I[0] ? WB_DAT_I[7:0] : ien_reg;
            default:
            begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign events = {bad_w, wrap, sw & ~sw_prev_reg};
   assign clr = (wr && WB_ADR_I == qenc_pkg::OFS_ICLR && WB_SEL_I[0]) ? WB_DAT_I[7:0] : 8'h00;

   // A new event beats a clear landing in the same cycle
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         sw_prev_reg <= 4'h0;
         ist_reg <= 8'h00;
         irq_reg <= 1'b0;
      end
      else
      begin
         sw_prev_reg <= sw;
         ist_reg <= (ist_reg & ~clr) | events;
         irq_reg <= |(ist_reg & ien_reg);
      end
   end

   // ----------------------------------------
   // Bus read and acknowledge
   // ----------------------------------------
   always_comb
   begin
      rdata = 32'h00000000;
      unique case (WB_ADR_I)
         qenc_pkg::OFS_THRESH: rdata = {24'h000000, thresh_reg};
         qenc_pkg::OFS_TBASE: rdata = {24'h000000, tbase_reg};
         qenc_pkg::OFS_COUNT0: rdata = count_reg[0];
         qenc_pkg::OFS_COUNT1: rdata = count_reg[1];
         qenc_pkg::OFS_SPEED: rdata = {16'h0000, speed_reg[1], speed_reg[0]};
         qenc_pkg::OFS_SWITCH: rdata = {28'h0000000, sw};
         qenc_pkg::OFS_ISTAT: rdata = {24'h000000, ist_reg};
         qenc_pkg::OFS_IEN: rdata = {24'h000000, ien_reg};
         default: rdata = 32'h00000000;
      endcase
   end

   // Every address answers; unmapped reads return zero
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end
      else
      begin
         ack_reg <= acc;
         dat_reg <= (acc && !WB_WE_I) ? rdata : 32'h00000000;
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = dat_reg;
   assign THRESH_CODE = thresh_reg;
   assign IRQ = irq_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   sequence s_sw_rise0;
      sw[0] && !sw_prev_reg[0];
   endsequence

   sequence s_count_up0;
      up_w[0] && !cnt_wr[0] && count_reg[0] != qenc_pkg::CNT_MAX;
   endsequence

   a_sync_agree_only: assert property (lvl_reg != $past(lvl_reg)
                                       |-> ((lvl_reg ^ $past(lvl_reg)) & ~$past(agree)) == 8'h00)
      else $error("level taken before stages agreed");
   a_count_up_step: assert property (s_count_up0 |=> count_reg[0] == $past(count_reg[0]) + 32'h00000001)
      else $error("counter did not increment");
   a_count_wrap_zero: assert property (up_w[1] && !cnt_wr[1] && count_reg[1] == qenc_pkg::CNT_MAX
                                       |=> count_reg[1] == 32'h00000000)
      else $error("counter did not roll to zero");
   a_thresh_default: assert property ($fell(RST) |-> THRESH_CODE == qenc_pkg::THRESH_RST)
      else $error("threshold not at default after reset");
   a_switch_flag_set: assert property (s_sw_rise0 |=> ist_reg[qenc_pkg::IRQ_SW_LSB])
      else $error("switch event not flagged");
   a_hold_no_count: assert property (hold[0] ##1 hold[0] |=> !up_w[0] && !down_w[0])
      else $error("counting while switch active");
   a_speed_sample: assert property (sample_tick && !hold[0] |=> speed_reg[0] == speed_sat($past(delta[0])))
      else $error("speed not sampled from counter change");
   a_irq_follows: assert property (|(ist_reg & ien_reg) |=> IRQ)
      else $error("interrupt not raised");
endmodule
`default_nettype wire

/* File: shared/qenc_pkg.sv */
/*
 Constants for the dual quadrature encoder input: register map, field
 positions, reset values and timing counts.
 Assumes a 250 MHz REF_CLK and a 32-bit classic Wishbone register bus.
*/
`default_nettype none
package qenc_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [5:0] OFS_THRESH = 6'h00;
   localparam logic [5:0] OFS_TBASE = 6'h04;
   localparam logic [5:0] OFS_COUNT0 = 6'h08;
   localparam logic [5:0] OFS_COUNT1 = 6'h0C;
   localparam logic [5:0] OFS_SPEED = 6'h10;
   localparam logic [5:0] OFS_SWITCH = 6'h14;
   localparam logic [5:0] OFS_ISTAT = 6'h18;
   localparam logic [5:0] OFS_ICLR = 6'h1C;
   localparam logic [5:0] OFS_IEN = 6'h20;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   // Threshold DAC code, 8 bits over 0..5V; mid scale is 2.5V
   localparam logic [7:0] THRESH_RST = 8'h80;
   localparam logic [7:0] TBASE_RST = 8'h00;
   localparam logic [31:0] CNT_MAX = 32'h7FFFFFFF;
   localparam logic [31:0] CNT_MIN = 32'h80000000;
   localparam logic [7:0] SPD_MAX = 8'h7F;
   localparam logic [7:0] SPD_MIN = 8'h81;
   // ----------------------------------------
   // Interrupt and speed field positions
   // ----------------------------------------
   localparam int IRQ_SW_LSB = 0;
   localparam int IRQ_WRAP_LSB = 4;
   localparam int IRQ_BAD_LSB = 6;
   localparam int SPD1_LSB = 8;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int INTERVAL_US = 256;
   localparam int INTERVAL_CYC = INTERVAL_US * CLK_MHZ;
   localparam int MAX_CPS = 250000;
   localparam int MIN_COUNT_GAP = (CLK_MHZ * 1000000) / MAX_CPS;
endpackage
`default_nettype wire

/* File: shared/quad_if.sv */
/*
 Carrier between the top level and one channel-pair decoder.
 Assumes levels already synchronised to the decoder's clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface quad_if;
   logic quad_phase_first;
   logic quad_phase_second;
   logic hold;
   logic up;
   logic down;
   logic bad;
   modport dec (input quad_phase_first, input quad_phase_second, input hold,
                output up, output down, output bad);
   modport top (output quad_phase_first, output quad_phase_second, output hold,
                input up, input down, input bad);
endinterface
`default_nettype wire

/* File: rtl/quad_decoder.sv */
/*
 Quadrature decoder for one encoder: one-cycle up, down and invalid pulses.
 Assumes synchronised, filtered levels on the quad_if carrier.
*/
`timescale 1ns/1ns
`default_nettype none
module quad_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Channel pair
   quad_if.dec q
);
   logic prev_a_reg;
   logic prev_b_reg;
   logic up_reg;
   logic down_reg;
   logic bad_reg;
   logic da;
   logic db;
   logic fwd;

   assign da = q.quad_phase_first ^ prev_a_reg;
   assign db = q.quad_phase_second ^ prev_b_reg;
   // First channel leading the second is forward; a swap reverses it
   assign fwd = (da & (q.quad_phase_first != prev_b_reg))
              | (db & (q.quad_phase_second == prev_a_reg));

   // Previous levels track even under hold, so release gives no false count
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         prev_a_reg <= 1'b0;
         prev_b_reg <= 1'b0;
      end
      else
      begin
         prev_a_reg <= q.quad_phase_first;
         prev_b_reg <= q.quad_phase_second;
      end
   end

   // One pulse per cycle is possible, far above the needed count rate
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         up_reg <= 1'b0;
         down_reg <= 1'b0;
         bad_reg <= 1'b0;
      end
      else
      begin
         up_reg <= ~q.hold & (da ^ db) & fwd;
         down_reg <= ~q.hold & (da ^ db) & ~fwd;
         bad_reg <= ~q.hold & da & db;
      end
   end

   assign q.up = up_reg;
   assign q.down = down_reg;
   assign q.bad = bad_reg;

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_fwd_step;
      !q.hold && !prev_a_reg && !prev_b_reg && q.quad_phase_first && !q.quad_phase_second;
   endsequence

   a_both_change_still: assert property (!q.hold && da && db |=> !up_reg && !down_reg && bad_reg)
      else $error("double change produced a count");
   a_forward_step: assert property (s_fwd_step |=> up_reg && !down_reg)
      else $error("forward step did not count up");
   a_hold_quiet: assert property (q.hold |=> !up_reg && !down_reg)
      else $error("count while switch held");
endmodule
`default_nettype wire

/* File: rtl/placeholder_fix.sv */
`timescale 1ns/1ns

/* File: tb/quad_enc_model.sv */
/*
 Behavioural pair of quadrature encoders with four limit switches, as seen
 through the threshold and low-level comparators of the block.
 Assumes the bench calls the tasks and clk is the block's own clock.
*/
`timescale 1ns/1ns
`default_nettype none
module quad_enc_model (
   // Clock
   input wire logic clk,
   // Comparator outputs toward the block
   output logic [3:0] quad_level,
   output logic [3:0] switch_low
);
   logic [1:0] idx [2];
   logic [1:0] swap;
   logic [3:0] closed;
   logic [3:0] raw;
   logic multi;
   initial
   begin
      idx[0] = 2'h0;
      idx[1] = 2'h0;
      swap = 2'h0;
      closed = 4'h0;
      multi = 1'b1;
   end
   // --------------------------------------------
   // Pins
   // --------------------------------------------
   // Gray order 00,10,11,01 of (first, second): first leads going forward
   always_comb
   begin
      for (int e = 0; e < 2; e++)
      begin
         raw[2*e] = swap[e] ? idx[e][1] : idx[e][1] ^ idx[e][0];
         raw[2*e+1] = swap[e] ? idx[e][1] ^ idx[e][0] : idx[e][1];
      end
   end
   // A closed switch grounds its pin, so the encoder level there is lost
   assign quad_level = raw & ~closed;
   // Direct wiring lets encoder lows reach the low detector
   assign switch_low = closed | (multi ? 4'h0 : ~raw);
   // --------------------------------------------
   // Motion and switches
   // --------------------------------------------
   task automatic step(input int e, input int dir, input int n, input int gap);
      repeat (n)
      begin
         repeat (gap) @(posedge clk);
         idx[e] <= idx[e] + dir[1:0];
      end
   endtask
   task automatic bad_step(input int e);
      @(posedge clk);
      idx[e] <= idx[e] + 2'h2;
   endtask
   task automatic set_switch(input int n, input logic on);
      @(posedge clk);
      closed[n] <= on;
   endtask
   task automatic cfg(input logic ml, input logic [1:0] sw);
      @(posedge clk);
      multi <= ml;
      swap <= sw;
   endtask
endmodule
`default_nettype wire

/* File: tb/dual_quadrature_encoder_input_tb_top.sv */
/*
 Self-checking bench for the dual quadrature encoder input.
 Assumes the encoder model drives the comparator pins and a short interval.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module dual_quadrature_encoder_input_tb_top;
   localparam int IV = 16;
   logic clk, rst, cyc, stb, we, ack, irq;
   logic [5:0] adr;
   logic [3:0] sel, lvl, swl;
   logic [31:0] wdat, rdat, d;
   logic [7:0] thr;
   int failures = 0;
   int tests_run = 0;
   quad_encoder_input #(.INTERVAL_CYCLES(IV)) dut_u (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .QUAD_LEVEL(lvl), .SWITCH_LOW(swl), .THRESH_CODE(thr), .IRQ(irq));
   quad_enc_model enc_u (.clk(clk), .quad_level(lvl), .switch_low(swl));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // --------------------------------------------
   // Bus access
   // --------------------------------------------
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] v, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      sel <= s;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50)
         `CHK("ack", 1'b1, ack)
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      wb(1'b1, a, v, 4'hF);
   endtask
   task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      `CHK(nm, e, d)
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // --------------------------------------------
   // Scenarios
   // --------------------------------------------
   task automatic t_regs();
      rd("thresh", qenc_pkg::OFS_THRESH, 32'h80);
      `CHK("thresh pin", qenc_pkg::THRESH_RST, thr)
      rd("count0", qenc_pkg::OFS_COUNT0, 32'h0);
      rd("unmapped", 6'h3C, 32'h0);
      rd("switch idle", qenc_pkg::OFS_SWITCH, 32'h0);
      wb(1'b1, qenc_pkg::OFS_THRESH, 32'h55, 4'hE);
      rd("thresh lanes", qenc_pkg::OFS_THRESH, 32'h80);
      wr(qenc_pkg::OFS_THRESH, 32'h33);
      `CHK("thresh new", 8'h33, thr)
   endtask
   task automatic t_count();
      enc_u.step(0, 1, 1, 6);
      rd("count early", qenc_pkg::OFS_COUNT0, 32'h0);
      enc_u.step(0, 1, 7, 4);
      repeat (10) @(posedge clk);
      rd("count fwd", qenc_pkg::OFS_COUNT0, 32'h8);
      enc_u.step(0, -1, 3, 4);
      repeat (10) @(posedge clk);
      rd("count rev", qenc_pkg::OFS_COUNT0, 32'h5);
      enc_u.step(1, 1, 4, 6);
      enc_u.cfg(1'b1, 2'h2);
      enc_u.step(1, 1, 3, 6);
      repeat (10) @(posedge clk);
      rd("count swap", qenc_pkg::OFS_COUNT1, 32'h1);
      enc_u.step(1, 1, 1, 6);
      enc_u.cfg(1'b1, 2'h0);
   endtask
   task automatic t_switch();
      wr(qenc_pkg::OFS_ICLR, 32'hFF);
      enc_u.set_switch(1, 1'b1);
      repeat (8) @(posedge clk);
      rd("switch 2", qenc_pkg::OFS_SWITCH, 32'h2);
      rd("switch stat", qenc_pkg::OFS_ISTAT, 32'h2);
      enc_u.step(0, -1, 1, 6);
      repeat (10) @(posedge clk);
      rd("count held", qenc_pkg::OFS_COUNT0, 32'h5);
      enc_u.set_switch(1, 1'b0);
      enc_u.step(0, 1, 1, 8);
      repeat (10) @(posedge clk);
      rd("count free", qenc_pkg::OFS_COUNT0, 32'h6);
   endtask
   task automatic t_bad();
      wr(qenc_pkg::OFS_ICLR, 32'hFF);
      enc_u.bad_step(1);
      repeat (10) @(posedge clk);
      rd("count bad", qenc_pkg::OFS_COUNT1, 32'h0);
      rd("bad stat", qenc_pkg::OFS_ISTAT, 32'h80);
      `CHK("irq masked", 1'b0, irq)
      wr(qenc_pkg::OFS_IEN, 32'h80);
      @(posedge clk);
      `CHK("irq on", 1'b1, irq)
      wr(qenc_pkg::OFS_ICLR, 32'h80);
      @(posedge clk);
      `CHK("irq off", 1'b0, irq)
   endtask
   task automatic t_wrap();
      wr(qenc_pkg::OFS_COUNT1, qenc_pkg::CNT_MAX);
      enc_u.step(1, 1, 1, 6);
      wr(qenc_pkg::OFS_COUNT0, qenc_pkg::CNT_MIN);
      enc_u.step(0, -1, 1, 6);
      repeat (10) @(posedge clk);
      rd("wrap up", qenc_pkg::OFS_COUNT1, 32'h0);
      rd("wrap down", qenc_pkg::OFS_COUNT0, 32'h0);
      rd("wrap stat", qenc_pkg::OFS_ISTAT, 32'h30);
   endtask
   task automatic t_speed();
      wr(qenc_pkg::OFS_TBASE, 32'h3);
      fork
         enc_u.step(0, 1, 60, 6);
         begin
            repeat (200) @(posedge clk);
            wb(1'b0, qenc_pkg::OFS_SPEED, 32'h0, 4'hF);
         end
      join
      `CHK("speed fwd", 1'b1, d[7:0] inside {8'h0A, 8'h0B})
      wr(qenc_pkg::OFS_TBASE, 32'h0);
      fork
         enc_u.step(0, -1, 60, 6);
         begin
            repeat (100) @(posedge clk);
            wb(1'b0, qenc_pkg::OFS_SPEED, 32'h0, 4'hF);
         end
      join
      `CHK("speed rev", 1'b1, d[7:0] inside {8'hFE, 8'hFD})
      repeat (60) @(posedge clk);
      rd("speed rest", qenc_pkg::OFS_SPEED, 32'h0);
   endtask
   task automatic t_direct();
      enc_u.cfg(1'b0, 2'h0);
      repeat (8) @(posedge clk);
      rd("switch direct", qenc_pkg::OFS_SWITCH, 32'h7);
   endtask
   initial
   begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h00;
      sel = 4'h0;
      wdat = 32'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_regs();
      t_count();
      t_switch();
      t_bad();
      t_wrap();
      t_speed();
      t_direct();
      summarize();
   end
   // A hang in any wait ends the run through the same verdict
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
